// ---- verilog/lwc_pkg.sv ----
/*
 lwc_pkg: offsets, field positions, reset values and command codes for the
 log-write command handler. assumes a 32-bit AXI4-Lite register bus.
*/
package lwc_pkg;
   // register byte offsets
   localparam logic [7:0] LWC_A_DATA = 8'h00;
   localparam logic [7:0] LWC_A_SCNT = 8'h08;
   localparam logic [7:0] LWC_A_SNUM = 8'h0C;
   localparam logic [7:0] LWC_A_CYLL = 8'h10;
   localparam logic [7:0] LWC_A_CYLH = 8'h14;
   localparam logic [7:0] LWC_A_DEVH = 8'h18;
   localparam logic [7:0] LWC_A_CMD = 8'h1C;
   localparam logic [7:0] LWC_A_ERR = 8'h20;
   localparam logic [7:0] LWC_A_STAT = 8'h24;
   localparam logic [7:0] LWC_A_IRQS = 8'h28;
   localparam logic [7:0] LWC_A_IRQM = 8'h2C;
   localparam logic [7:0] LWC_A_CFG = 8'h30;
   localparam logic [7:0] LWC_A_LPTR = 8'h34;
   localparam logic [7:0] LWC_A_LRD = 8'h38;
   // command codes
   localparam logic [7:0] LWC_CMD_LOG_WRITE = 8'h3F;
   localparam logic [7:0] LWC_CMD_QWRITE = 8'h61;
   // field positions
   localparam int LWC_DEVH_FUA = 7;
   localparam int LWC_ST_BSY = 7;
   localparam int LWC_ST_RDY = 6;
   localparam int LWC_ST_DSC = 4;
   localparam int LWC_ST_DRQ = 3;
   localparam int LWC_ST_ERR = 0;
   localparam int LWC_ER_UNC = 6;
   localparam int LWC_ER_ABT = 2;
   localparam int LWC_IRQ_BLK = 0;
   localparam int LWC_IRQ_DONE = 1;
   localparam int LWC_IRQ_ABORT = 2;
   localparam int LWC_CFG_WCE = 0;
   // log geometry: 16 logs, up to 4 sectors, 128 words of 32 bits per sector
   localparam int LWC_NLOG = 16;
   localparam int LWC_MEM_AW = 13;
   localparam logic [6:0] LWC_LAST_WORD = 7'h7F;
   // directory: 4-bit sector count per log, log 0 in the low nibble
   localparam logic [63:0] LWC_LOG_SIZES = 64'h4444_2222_1111_0001;
   // read-only logs (the directory itself among them)
   localparam logic [15:0] LWC_LOG_RO = 16'h000F;
   // reset values and bus response codes
   localparam logic [2:0] LWC_IRQM_RST = 3'h0;
   localparam logic [0:0] LWC_CFG_RST = 1'h1;
   localparam logic [1:0] LWC_RESP_OKAY = 2'h0;
   localparam logic [1:0] LWC_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      LWC_IDLE = 2'b00,
      LWC_LOG_DRQ = 2'b10,
      LWC_QW_DATA = 2'b01,
      LWC_QW_MEDIA = 2'b11
   } lwc_state_t;

   // byte-enable merge of a 16-bit pair: each lane takes the write byte when enabled, else keeps the old one
   function automatic logic [15:0] lwc_merge16(input logic [15:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
      lwc_merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   function automatic logic [3:0] lwc_log_size(input logic [3:0] idx);
      lwc_log_size = LWC_LOG_SIZES[{idx, 2'b00} +: 4];
   endfunction
endpackage

// ---- verilog/lwc_top.sv ----
/*
 lwc_top: device-side command block for the extended log write and the
 completion and failure reporting of the queued DMA write. assumes an
 AXI4-Lite master on mclk, and a media/DMA engine on the same clock that
 moves queued-write data and reports commit and failure.
*/
`timescale 1ns/1ps
module lwc_top
   import lwc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] log_feature_en,
   output logic qw_start,
   output logic qw_fua,
   input wire logic qw_xfer_done,
   input wire logic qw_media_done,
   input wire logic qw_media_fail,
   input wire logic [47:0] qw_fail_lba,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic wr_fire, rd_fire, wr_hit, rd_hit;
   logic [15:0] scnt_q, snum_q, cyll_q, cylh_q;
   logic [7:0] devh_q, err_q;
   logic bsy_q, drq_q, errst_q;
   logic [2:0] irqs_q, irqm_q;
   logic wce_q;
   logic [LWC_MEM_AW-1:0] lptr_q;
   lwc_state_t state_q;
   logic fua_q;
   logic [3:0] log_q;
   logic [15:0] left_q;
   logic [1:0] sect_q;
   logic [6:0] word_q;
   logic [31:0] log_mem [2**LWC_MEM_AW];
   logic cmd_wr, data_wr, lw_bad, sect_end;
   logic ev_blk, ev_done, ev_abort;
   logic [3:0] sel_size;
   logic [16:0] span;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: address and data held independently, write done once both sit
   // readies drop with ce, else a beat offered while frozen would be lost
   assign s_axi_awready = ce & ~aw_full_q;
   assign s_axi_wready = ce & ~w_full_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = ce & ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign wr_fire = ce & aw_full_q & w_full_q & ~bvalid_q;
   assign rd_fire = ce & s_axi_arvalid & ~rvalid_q;

   always_comb begin
      case (awaddr_q)
         LWC_A_DATA, LWC_A_SCNT, LWC_A_SNUM, LWC_A_CYLL, LWC_A_CYLH, LWC_A_DEVH, LWC_A_CMD,
         LWC_A_IRQM, LWC_A_CFG, LWC_A_LPTR: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_comb begin
      case (s_axi_araddr)
         LWC_A_SCNT, LWC_A_SNUM, LWC_A_CYLL, LWC_A_CYLH, LWC_A_DEVH, LWC_A_ERR, LWC_A_STAT,
         LWC_A_IRQS, LWC_A_IRQM, LWC_A_CFG, LWC_A_LPTR, LWC_A_LRD: rd_hit = 1'b1;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= LWC_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? LWC_RESP_OKAY : LWC_RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= LWC_RESP_OKAY;
      end else if (ce) begin
         if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? LWC_RESP_OKAY : LWC_RESP_SLVERR;
            case (s_axi_araddr)
               LWC_A_SCNT: rdata_q <= {16'h0000, scnt_q};
               LWC_A_SNUM: rdata_q <= {16'h0000, snum_q};
               LWC_A_CYLL: rdata_q <= {16'h0000, cyll_q};
               LWC_A_CYLH: rdata_q <= {16'h0000, cylh_q};
               LWC_A_DEVH: rdata_q <= {24'h00_0000, devh_q};
               LWC_A_ERR: rdata_q <= {24'h00_0000, err_q};
               LWC_A_STAT: rdata_q <= {24'h00_0000, bsy_q, 1'b1, 1'b0, 1'b1, drq_q, 2'b00, errst_q};
               LWC_A_IRQS: rdata_q <= {29'h0000_0000, irqs_q};
               LWC_A_IRQM: rdata_q <= {29'h0000_0000, irqm_q};
               LWC_A_CFG: rdata_q <= {31'h0000_0000, wce_q};
               LWC_A_LPTR: rdata_q <= {19'h0_0000, lptr_q};
               LWC_A_LRD: rdata_q <= log_mem[lptr_q];
               default: rdata_q <= 32'h0000_0000;
            endcase
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command acceptance and log-write validation
   assign cmd_wr = wr_fire & (awaddr_q == LWC_A_CMD) & wstrb_q[0] & (state_q == LWC_IDLE);
   assign data_wr = wr_fire & (awaddr_q == LWC_A_DATA) & (state_q == LWC_LOG_DRQ);
   assign sect_end = data_wr & (word_q == LWC_LAST_WORD);
   assign sel_size = lwc_log_size(snum_q[3:0]);
   assign span = {1'b0, cyll_q} + {1'b0, scnt_q};
   assign lw_bad = (snum_q[7:4] != 4'h0)
                 | (sel_size == 4'h0)
                 | ~log_feature_en[snum_q[3:0]]
                 | LWC_LOG_RO[snum_q[3:0]]
                 | (scnt_q == 16'h0000)
                 | (scnt_q > {12'h000, sel_size})
                 | (span > {13'h0000, sel_size});

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         scnt_q <= 16'h0000;
         snum_q <= 16'h0000;
         cyll_q <= 16'h0000;
         cylh_q <= 16'h0000;
         devh_q <= 8'h00;
      end else if (ce) begin
         if (state_q != LWC_IDLE && qw_media_fail) begin
            snum_q <= {qw_fail_lba[31:24], qw_fail_lba[7:0]};
            cyll_q <= {qw_fail_lba[39:32], qw_fail_lba[15:8]};
            cylh_q <= {qw_fail_lba[47:40], qw_fail_lba[23:16]};
         end else if (wr_fire && !bsy_q) begin
            case (awaddr_q)
               LWC_A_SCNT: scnt_q <= lwc_merge16(scnt_q, wdata_q, wstrb_q);
               LWC_A_SNUM: snum_q <= lwc_merge16(snum_q, wdata_q, wstrb_q);
               LWC_A_CYLL: cyll_q <= lwc_merge16(cyll_q, wdata_q, wstrb_q);
               LWC_A_CYLH: cylh_q <= lwc_merge16(cylh_q, wdata_q, wstrb_q);
               LWC_A_DEVH: devh_q <= wstrb_q[0] ? wdata_q[7:0] : devh_q;
               default: devh_q <= devh_q;
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irqm_q <= LWC_IRQM_RST;
         wce_q <= LWC_CFG_RST;
         lptr_q <= '0;
      end else if (ce && wr_fire && wstrb_q[0]) begin
         if (awaddr_q == LWC_A_IRQM) irqm_q <= wdata_q[2:0];
         if (awaddr_q == LWC_A_CFG) wce_q <= wdata_q[LWC_CFG_WCE];
         if (awaddr_q == LWC_A_LPTR) lptr_q <= wdata_q[LWC_MEM_AW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command sequencer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= LWC_IDLE;
         bsy_q <= 1'b0;
         drq_q <= 1'b0;
         errst_q <= 1'b0;
         err_q <= 8'h00;
         fua_q <= 1'b0;
         log_q <= 4'h0;
         left_q <= 16'h0000;
         sect_q <= 2'b00;
         word_q <= 7'h00;
      end else if (ce) begin
         case (state_q)
            LWC_IDLE: begin
               if (cmd_wr && wdata_q[7:0] == LWC_CMD_LOG_WRITE) begin
                  err_q <= 8'h00;
                  if (lw_bad) begin
                     err_q[LWC_ER_ABT] <= 1'b1;
                     errst_q <= 1'b1;
                     bsy_q <= 1'b0;
                  end else begin
                     errst_q <= 1'b0;
                     drq_q <= 1'b1;
                     log_q <= snum_q[3:0];
                     left_q <= scnt_q;
                     sect_q <= cyll_q[1:0];
                     word_q <= 7'h00;
                     state_q <= LWC_LOG_DRQ;
                  end
               end else if (cmd_wr && wdata_q[7:0] == LWC_CMD_QWRITE) begin
                  err_q <= 8'h00;
                  errst_q <= 1'b0;
                  bsy_q <= 1'b1;
                  fua_q <= devh_q[LWC_DEVH_FUA];
                  state_q <= LWC_QW_DATA;
               end else if (cmd_wr) begin
                  err_q <= 8'h00;
                  err_q[LWC_ER_ABT] <= 1'b1;
                  errst_q <= 1'b1;
               end
            end
            LWC_LOG_DRQ: begin
               if (data_wr) word_q <= word_q + 7'h01;
               if (sect_end) begin
                  sect_q <= sect_q + 2'b01;
                  left_q <= left_q - 16'h0001;
                  if (left_q == 16'h0001) begin
                     drq_q <= 1'b0;
                     state_q <= LWC_IDLE;
                  end
               end
            end
            LWC_QW_DATA: begin
               if (qw_media_fail) begin
                  err_q[LWC_ER_UNC] <= 1'b1;
                  errst_q <= 1'b1;
                  bsy_q <= 1'b0;
                  state_q <= LWC_IDLE;
               end else if (qw_xfer_done) begin
                  if (!fua_q && wce_q) begin
                     bsy_q <= 1'b0;
                     state_q <= LWC_IDLE;
                  end else begin
                     state_q <= LWC_QW_MEDIA;
                  end
               end
            end
            LWC_QW_MEDIA: begin
               if (qw_media_fail) begin
                  err_q[LWC_ER_UNC] <= 1'b1;
                  errst_q <= 1'b1;
                  bsy_q <= 1'b0;
                  state_q <= LWC_IDLE;
               end else if (qw_media_done) begin
                  bsy_q <= 1'b0;
                  state_q <= LWC_IDLE;
               end
            end
            default: state_q <= LWC_IDLE;
         endcase
      end
   end

   // log store: the sector index cannot pass the log size, validation saw to that
   always_ff @(posedge mclk) begin
      if (ce && data_wr) begin
         log_mem[{log_q, sect_q, word_q}] <= wdata_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         qw_start <= 1'b0;
         qw_fua <= 1'b0;
      end else if (ce) begin
         qw_start <= cmd_wr & (wdata_q[7:0] == LWC_CMD_QWRITE);
         if (cmd_wr) qw_fua <= devh_q[LWC_DEVH_FUA];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status: read clears, a new event in the same cycle wins
   assign ev_blk = ce & sect_end;
   assign ev_abort = cmd_wr & ((wdata_q[7:0] == LWC_CMD_LOG_WRITE) ? lw_bad : (wdata_q[7:0] != LWC_CMD_QWRITE));
   assign ev_done = ce & ((sect_end & (left_q == 16'h0001))
                  | ((state_q == LWC_QW_DATA) & ~qw_media_fail & qw_xfer_done & ~fua_q & wce_q)
                  | ((state_q == LWC_QW_DATA || state_q == LWC_QW_MEDIA) & qw_media_fail)
                  | ((state_q == LWC_QW_MEDIA) & qw_media_done));

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irqs_q <= 3'h0;
      end else if (ce) begin
         irqs_q <= ((rd_fire && s_axi_araddr == LWC_A_IRQS) ? 3'h0 : irqs_q)
                 | {ev_abort, ev_done, ev_blk};
      end
   end

   assign irq = |(irqs_q & irqm_q);

endmodule

// ---- test/lwc_media_model.sv ----
/*
 lwc_media_model: behavioural media/DMA engine facing the queued-write ports.
 assumes the same mclk and synchronous rst_n as the handler.
*/
`timescale 1ns/1ps
module lwc_media_model #(
   parameter int XFER_LAT = 3,
   parameter int MEDIA_LAT = 12,
   parameter logic [47:0] BAD_LBA = 48'hA1B2C3D4E5F6
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic qw_start,
   input wire logic fail_mode,
   output logic qw_xfer_done,
   output logic qw_media_done,
   output logic qw_media_fail,
   output logic [47:0] qw_fail_lba
);
   int cnt_q;
   ////////////////////////////////////////////////////////////////
   // data first, media commit much later, so fua shows in between
   always_ff @(posedge mclk) begin
      qw_xfer_done <= 1'b0;
      qw_media_done <= 1'b0;
      qw_media_fail <= 1'b0;
      if (!rst_n) begin
         cnt_q <= 0;
      end else if (qw_start) begin
         cnt_q <= 1;
      end else if (cnt_q != 0) begin
         cnt_q <= cnt_q + 1;
         if (cnt_q == XFER_LAT) begin
            qw_xfer_done <= 1'b1;
         end
         if (cnt_q == MEDIA_LAT) begin
            cnt_q <= 0;
            qw_media_fail <= fail_mode;
            qw_media_done <= !fail_mode;
         end
      end
   end
   // address only valid with the fail pulse; garbage otherwise
   assign qw_fail_lba = qw_media_fail ? BAD_LBA : ~BAD_LBA;
endmodule

// ---- test/lwc_top_assertions.sv ----
/*
 lwc_top_assertions: port-level checks of the handler's register bus, plus quiet outputs after reset and the one-cycle qw_start pulse.
 assumes one clock domain, mclk, with synchronous rst_n.
*/
`timescale 1ns/1ps
module lwc_top_assertions
   import lwc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic qw_start,
   input wire logic irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // both taken with no answer pending, then one enabled cycle for the write itself
   sequence aw_w_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce && !s_axi_bvalid ##1 ce;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready && ce;
   endsequence
   ////////////////////////////////////////////////////////////////
   a_write_answer: assert property (aw_w_taken |=> s_axi_bvalid) else $error("write response missing");
   a_read_answer: assert property (ar_taken |=> s_axi_rvalid) else $error("read data missing");
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_unmapped_write: assert property (s_axi_awaddr >= 8'h3C ##0 aw_w_taken |=> s_axi_bresp == LWC_RESP_SLVERR)
      else $error("unmapped write not refused");
   a_unmapped_read: assert property (s_axi_araddr >= 8'h3C ##0 ar_taken |=> s_axi_rdata == 32'h0
      && s_axi_rresp == LWC_RESP_SLVERR) else $error("unmapped read not refused");
   a_reset_quiet: assert property ($rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !qw_start)
      else $error("outputs busy after reset");
   a_start_pulse: assert property (qw_start && ce |=> !qw_start) else $error("start longer than one cycle");
endmodule
bind lwc_top lwc_top_assertions i_lwc_top_assertions (.mclk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .qw_start, .irq);

// ---- test/lwc_top_test.sv ----
/*
 lwc_top_test: self-checking bench for the log-write command handler.
 assumes the media model on the queued-write ports and ce held high until the closing clock-enable test.
*/
`timescale 1ns/1ps
module lwc_top_test;
   import lwc_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, fail_mode = 1'b0;
   logic [15:0] log_feature_en = 16'hFFFF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, last_bresp, last_rresp;
   logic [31:0] s_axi_rdata, rword;
   logic qw_start, qw_fua, qw_xfer_done, qw_media_done, qw_media_fail;
   logic [47:0] qw_fail_lba;
   int fail_count = 0;
   int num_checks = 0;
   // aborting setups: {feature off, log address, count, first sector}
   logic [40:0] rows [8] = '{{1'b0, 8'h01, 16'h0001, 16'h0000},
      {1'b0, 8'h00, 16'h0001, 16'h0000}, {1'b0, 8'h08, 16'h0003, 16'h0000},
      {1'b0, 8'h08, 16'h0002, 16'h0001}, {1'b0, 8'h04, 16'h0000, 16'h0000},
      {1'b1, 8'h04, 16'h0001, 16'h0000}, {1'b0, 8'h14, 16'h0001, 16'h0000},
      {1'b0, 8'h0C, 16'h0105, 16'h0000}};
   always #5 mclk = ~mclk;
   lwc_top i_lwc_top (.mclk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .log_feature_en, .qw_start, .qw_fua, .qw_xfer_done, .qw_media_done, .qw_media_fail, .qw_fail_lba, .irq);
   lwc_media_model i_lwc_media_model (.mclk, .rst_n, .qw_start, .fail_mode, .qw_xfer_done, .qw_media_done,
      .qw_media_fail, .qw_fail_lba);
   ////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // write address and data offered together, each dropped once taken
   // hold keeps bready low for that many answer cycles; ready is left up after, so back-to-back calls are clean
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input int hold = 0);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (hold == 0);
      do begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && hold > 0) begin
            hold--;
            if (hold == 0) s_axi_bready <= 1'b1;
         end
      end while (!(s_axi_bvalid && s_axi_bready));
      last_bresp = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a, input int hold = 0);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (hold == 0);
      do begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && hold > 0) begin
            hold--;
            if (hold == 0) s_axi_rready <= 1'b1;
         end
      end while (!(s_axi_rvalid && s_axi_rready));
      rword = s_axi_rdata;
      last_rresp = s_axi_rresp;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk($sformatf("register %h", a), rword, e);
   endtask
   task automatic setup(input logic [7:0] lg, input logic [15:0] cnt, input logic [15:0] first);
      wr(LWC_A_SCNT, {16'h0, cnt}, 4'h3);
      wr(LWC_A_SNUM, {24'h0, lg}, 4'h1);
      wr(LWC_A_CYLL, {16'h0, first}, 4'h3);
      wr(LWC_A_CMD, {24'h0, LWC_CMD_LOG_WRITE}, 4'h1);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge mclk);
      fail_count++;
      end_of_test();
   end
   initial begin
      int s, w, f;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      rc(LWC_A_STAT, 32'h50);
      rc(LWC_A_ERR, 32'h0);
      rc(LWC_A_IRQM, 32'h0);
      rc(LWC_A_CFG, 32'h1);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         log_feature_en <= rows[i][40] ? 16'hFFEF : 16'hFFFF;
         setup(rows[i][39:32], rows[i][31:16], rows[i][15:0]);
         rc(LWC_A_STAT, 32'h51);
         rc(LWC_A_ERR, 32'h4);
         rc(LWC_A_IRQS, 32'h4);
         chk("masked irq", {31'h0, irq}, 32'h0);
      end
      $display("test abort rows done");
      log_feature_en <= 16'hFFFF;
      wr(LWC_A_IRQM, 32'h1, 4'h1);
      setup(8'h0C, 16'h0002, 16'h0001);
      rc(LWC_A_STAT, 32'h58);
      for (s = 0; s < 2; s++) begin
         for (w = 0; w < 128; w++) wr(LWC_A_DATA, 32'hA500_0000 + 32'(s * 256 + w), 4'hF);
         chk("irq", {31'h0, irq}, 32'h1);
         rc(LWC_A_IRQS, (s == 1) ? 32'h3 : 32'h1);
         chk("irq", {31'h0, irq}, 32'h0);
      end
      rc(LWC_A_STAT, 32'h50);
      // stored from sector index 1, not 0
      for (s = 0; s < 2; s++) begin
         for (w = 0; w < 128; w += 127) begin
            wr(LWC_A_LPTR, {19'h0, 4'hC, 2'(s + 1), 7'(w)}, 4'h3);
            rc(LWC_A_LRD, 32'hA500_0000 + 32'(s * 256 + w));
         end
      end
      $display("test log write done");
      // third pass: fua clear but write cache off, so completion still waits for the media
      for (f = 0; f < 3; f++) begin
         wr(LWC_A_CFG, {31'h0, f != 2}, 4'h1);
         wr(LWC_A_DEVH, 32'(f == 1) << LWC_DEVH_FUA, 4'h1);
         wr(LWC_A_CMD, {24'h0, LWC_CMD_QWRITE}, 4'h1);
         chk("fua", {31'h0, qw_fua}, 32'(f == 1));
         @(posedge mclk iff qw_xfer_done);
         rc(LWC_A_STAT, (f != 0) ? 32'hD0 : 32'h50);
         repeat (16) @(posedge mclk);
         rc(LWC_A_STAT, 32'h50);
      end
      fail_mode <= 1'b1;
      wr(LWC_A_DEVH, 32'h80, 4'h1);
      wr(LWC_A_CMD, {24'h0, LWC_CMD_QWRITE}, 4'h1);
      repeat (16) @(posedge mclk);
      rc(LWC_A_STAT, 32'h51);
      rc(LWC_A_ERR, 32'h40);
      rc(LWC_A_SNUM, 32'hC3F6);
      rc(LWC_A_CYLL, 32'hB2E5);
      rc(LWC_A_CYLH, 32'hA1D4);
      $display("test queued write done");
      // answers held back a few cycles so the held-response checks see traffic
      wr(8'h3C, 32'h1234, 4'hF, 2);
      chk("bresp", {30'h0, last_bresp}, {30'h0, LWC_RESP_SLVERR});
      rd(8'h3C, 2);
      chk("rdata", rword, 32'h0);
      chk("rresp", {30'h0, last_rresp}, {30'h0, LWC_RESP_SLVERR});
      $display("test unmapped done");
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rc(LWC_A_ERR, 32'h0);
      rc(LWC_A_CFG, 32'h1);
      rc(LWC_A_STAT, 32'h50);
      $display("test mid reset done");
      ce <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("ready when frozen", {31'h0, s_axi_awready | s_axi_arready}, 32'h0);
      ce <= 1'b1;
      $display("test clock enable done");
      end_of_test();
   end
endmodule
